// ==== design/rdib_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef RDIB_MAP_SVH
`define RDIB_MAP_SVH

`define RDIB_ADDR_IDENTITY 8'h00
`define RDIB_ADDR_INPUT_FAULT 8'h02
`define RDIB_ADDR_LOOP_EVENTS 8'h03
`define RDIB_ADDR_INPUT_ENABLES 8'h04
`define RDIB_ADDR_LOOP_ENABLES 8'h05
`define RDIB_ADDR_REVISION_EXT 8'hc6

`define RDIB_PART_ID_LSB 0
`define RDIB_PART_ID_MSB 4
`define RDIB_REV_LSB 5
`define RDIB_REV_MSB 6
`define RDIB_READY_BIT 7

// arbitrary neutral values
`define RDIB_PART_ID 5'h1a
`define RDIB_REV_LOW 2'h0
`define RDIB_REV_EXT_RESET 8'h03

`define RDIB_EVENT_RESET 4'h0
`define RDIB_ENABLE_RESET 4'h0

`define RDIB_CLK_HZ 50000000
`define RDIB_READY_MS 50
`define RDIB_READY_CYCLES ((`RDIB_CLK_HZ / 1000) * `RDIB_READY_MS)

`endif

// ==== design/rdib_pkg.sv ====
// types shared by the status bank
package rdib_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rdib_req_type;

    typedef struct packed {
        logic [3:0] input_fault;
        logic [1:0] loop0;
        logic [1:0] loop1;
    } rdib_events_type;

    typedef enum logic {RDIB_WAITING, RDIB_READY} rdib_phase_type;

endpackage

// ==== design/rdib_status_bank.sv ====
// identity, ready flag and interrupt status bank of the dual-loop synchronizer
//
// Function
// R1 - the identity register returns a fixed five-bit part identifier in bits 4:0, read only.
// R2 - bits 6:5 hold a two-bit revision, extended by a second revision register at 0xc6.
// R3 - the ready bit 7 reads low after reset and goes high within 50 ms.
// R4 - the host waits 40 ms after reset and programs only once the ready bit reads high.
// R5 - input-fault bit 0 sets on an input 0 fault while its enable bit is high.
// R6 - input-fault bits 1 to 3 behave alike for inputs 1 to 3, each with its own enable.
// R7 - any set bit in either event register drives the interrupt request high.
// R8 - loop bit 0 sets when loop 0 enters holdover while its enable is high.
// R9 - loop bit 1 sets when loop 0 loses lock while its enable is high.
// R10 - loop bits 2 and 3 report holdover and unlock of loop 1 in the same way.
// R11 - input enable bits 0 to 3 each gate one input; zero blocks the flag and the interrupt.
// R12 - the loop enable register holds hold and unlock enables for loop 0 then loop 1.
// R13 - each event bit stays set until the host writes one to it.
// R14 - the interrupt request falls only once every event bit is clear.
`timescale 1ns/100ps
`include "rdib_map.svh"

module rdib_status_bank
    import rdib_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire rdib_req_type req,
    input wire rdib_events_type events,
    output logic [7:0] rdata,
    output logic ready,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        rdib_phase_type phase;
        logic [31:0] ready_count;
        logic [3:0] input_enables;
        logic [3:0] loop_enables;
        logic [7:0] revision_ext;
        logic [7:0] rdata;
        logic [7:0] events_in_q1;
        logic [7:0] events_in_q2;
    } rdib_bank_state_type;

    rdib_bank_state_type state;
    rdib_bank_state_type next_state;

    logic [3:0] input_flags;
    logic [3:0] loop_flags;
    logic [3:0] loop_events_sync;
    logic wr_input;
    logic wr_loop;

    ////////////////////////////////////////////////////////////////////////////////
    // event latches; monitor outputs are synchronised first since they come from elsewhere

    assign wr_input = req.wr && (req.addr == `RDIB_ADDR_INPUT_FAULT);
    assign wr_loop = req.wr && (req.addr == `RDIB_ADDR_LOOP_EVENTS);
    assign loop_events_sync = state.events_in_q2[3:0];

    rdib_sticky_bits #(.width(4)) u_input_flags
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .event_in(state.events_in_q2[7:4]), // see R6
        .enable(state.input_enables),
        .clear_mask(req.wdata[3:0]),
        .clear_strobe(wr_input),
        .flags(input_flags)
    );

    rdib_sticky_bits #(.width(4)) u_loop_flags
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .event_in(loop_events_sync), // see R8 see R9 see R10
        .enable(state.loop_enables), // see R12
        .clear_mask(req.wdata[3:0]),
        .clear_strobe(wr_loop),
        .flags(loop_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // registers, ready timer and read data

    always_comb
    begin
        next_state = state;
        next_state.events_in_q1 = {events.input_fault, events.loop1, events.loop0};
        next_state.events_in_q2 = state.events_in_q1;
        // ready fires at the worst-case 50 ms figure, 10 ms after the 40 ms host wait ends
        unique case (state.phase)
            RDIB_WAITING:
            begin
                if (state.ready_count == 32'(`RDIB_READY_CYCLES - 1))
                begin
                    next_state.phase = RDIB_READY; // see R3
                end
                else
                begin
                    next_state.ready_count = state.ready_count + 32'h1;
                end
            end
            RDIB_READY:
            begin
                next_state.ready_count = state.ready_count;
            end
        endcase
        if (req.wr)
        begin
            unique case (req.addr)
                `RDIB_ADDR_INPUT_ENABLES: next_state.input_enables = req.wdata[3:0]; // see R11
                `RDIB_ADDR_LOOP_ENABLES: next_state.loop_enables = req.wdata[3:0]; // see R12
                `RDIB_ADDR_REVISION_EXT: next_state.revision_ext = req.wdata;
                default: next_state.input_enables = next_state.input_enables;
            endcase
        end
        if (req.rd)
        begin
            unique case (req.addr)
                `RDIB_ADDR_IDENTITY:
                begin
                    next_state.rdata = {state.phase == RDIB_READY, `RDIB_REV_LOW,
                        `RDIB_PART_ID}; // see R1 see R2 see R3
                end
                `RDIB_ADDR_INPUT_FAULT: next_state.rdata = {4'h0, input_flags};
                `RDIB_ADDR_LOOP_EVENTS: next_state.rdata = {4'h0, loop_flags};
                `RDIB_ADDR_INPUT_ENABLES: next_state.rdata = {4'h0, state.input_enables};
                `RDIB_ADDR_LOOP_ENABLES: next_state.rdata = {4'h0, state.loop_enables};
                `RDIB_ADDR_REVISION_EXT: next_state.rdata = state.revision_ext; // see R2
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state.phase <= RDIB_WAITING;
            state.ready_count <= 32'h0;
            state.input_enables <= `RDIB_ENABLE_RESET;
            state.loop_enables <= `RDIB_ENABLE_RESET;
            state.revision_ext <= `RDIB_REV_EXT_RESET;
            state.rdata <= 8'h00;
            state.events_in_q1 <= 8'h00;
            state.events_in_q2 <= 8'h00;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdata = state.rdata;
    assign ready = (state.phase == RDIB_READY);
    // level output, so it stays up until the last flag is cleared
    assign irq = |{input_flags, loop_flags}; // see R7 see R14

endmodule

// ==== design/rdib_sticky_bits.sv ====
// sticky event bits gated by enables, cleared by writing one
`timescale 1ns/100ps

module rdib_sticky_bits
    import rdib_pkg::*;
#(
    parameter int width = 4
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [width-1:0] event_in,
    input wire logic [width-1:0] enable,
    input wire logic [width-1:0] clear_mask,
    input wire logic clear_strobe,
    output logic [width-1:0] flags
);

    typedef struct packed {
        logic [width-1:0] flags;
    } rdib_sticky_state_type;

    rdib_sticky_state_type state;
    rdib_sticky_state_type next_state;

    always_comb
    begin
        next_state = state;
        // set beats clear in the same cycle so no event is lost
        if (clear_strobe)
        begin
            next_state.flags = state.flags & ~clear_mask; // see R13
        end
        next_state.flags = next_state.flags | (event_in & enable); // see R5 see R11
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign flags = state.flags;

endmodule

// ==== tb/rdib_checker.sv ====
// port checker for the status bank
`timescale 1ns/100ps
`include "rdib_map.svh"
module rdib_checker
    import rdib_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire rdib_req_type req,
    input wire rdib_events_type events,
    input wire logic [7:0] rdata,
    input wire logic ready,
    input wire logic irq
);
    logic [7:0] en;
    logic [21:0] age;
    logic cause;
    assign cause = |({events.loop1, events.loop0, events.input_fault} & en);
    // shadow of both enable registers, so that masked events are known
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            en <= 8'h00;
            age <= 22'h0;
        end
        else
        begin
            // saturates so a long run cannot wrap back under the ready bound
            if (age != 22'h3fffff)
                age <= age + 22'h1;
            if (req.wr && req.addr == 8'h04)
                en[3:0] <= req.wdata[3:0];
            if (req.wr && req.addr == 8'h05)
                en[7:4] <= req.wdata[3:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence held_cause;
        cause [*3];
    endsequence
    chk_ready_wait: assert property (age < 22'd2499990 |-> !ready)
        else $error("ready early");
    chk_id_fields: assert property (req.rd && req.addr == 8'h00 |=>
        rdata == {$past(ready), `RDIB_REV_LOW, `RDIB_PART_ID}) else $error("bad identity");
    chk_irq_sets: assert property (held_cause |=> irq)
        else $error("irq missing");
    chk_irq_cause: assert property ($rose(irq) |-> $past(cause, 2) || $past(cause, 3))
        else $error("irq without cause");
    chk_irq_sticky: assert property (irq && !req.wr |=> irq)
        else $error("irq dropped");
    chk_clear_read: assert property (req.rd && req.addr inside {8'h02, 8'h03} && !irq
        |=> rdata == 8'h00) else $error("flag without irq");
    chk_input_enables: assert property (req.rd && req.addr == 8'h04
        |=> rdata == {4'h0, $past(en[3:0])}) else $error("bad input enables");
    chk_loop_enables: assert property (req.rd && req.addr == 8'h05
        |=> rdata == {4'h0, $past(en[7:4])}) else $error("bad loop enables");
    chk_unmapped_zero: assert property (req.rd && !(req.addr inside
        {8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'hc6}) |=> rdata == 8'h00) else $error("unmapped");
endmodule
bind rdib_status_bank rdib_checker u_chk (.ref_clk(ref_clk), .rst(rst), .req(req),
    .events(events), .rdata(rdata), .ready(ready), .irq(irq));

// ==== tb/rdib_monitors.sv ====
// model of the input monitors and loop state machines
`timescale 1ns/100ps
module rdib_monitors
    import rdib_pkg::*;
(
    input wire logic ref_clk,
    input wire rdib_events_type level,
    output rdib_events_type events
);
    // event levels change just after an edge, unrelated to host traffic
    always_ff @(posedge ref_clk)
        events <= level;
endmodule

// ==== tb/rdib_status_bank_tb.sv ====
// self-checking bench for the status bank
`timescale 1ns/100ps
`include "rdib_map.svh"
module rdib_status_bank_tb
    import rdib_pkg::*;
;
    logic ref_clk, rst, pend, ready, irq;
    logic [7:0] lev, en, ex, rdata;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    int failures, total_checks;
    rdib_req_type req;
    rdib_events_type ev, lev_s;
    assign lev_s = '{input_fault: lev[3:0], loop0: lev[5:4], loop1: lev[7:6]};
    rdib_monitors u_mon (.ref_clk(ref_clk), .level(lev_s), .events(ev));
    rdib_status_bank u_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .events(ev),
        .rdata(rdata), .ready(ready), .irq(irq));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want)
        begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one access; a read notes its expected data for the watcher
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
        input logic [7:0] e);
        req.wr <= w;
        req.rd <= !w;
        req.addr <= a;
        req.wdata <= d;
        if (!w)
            exp_q.push_back(e);
        @(posedge ref_clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    // irq is looked at mid-cycle, clear of the edge that moves it
    task automatic irq_is(input logic e);
        @(negedge ref_clk);
        check({7'h0, irq}, {7'h0, e});
        @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge ref_clk)
        pend <= req.rd;
    always @(negedge ref_clk)
        if (pend && exp_q.size() > 0)
            check(rdata, exp_q.pop_front());
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        test_done();
    end
    initial
    begin
        rst = 1'b1;
        req = '0;
        lev = 8'h00;
        seed = 32'h5abe;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // ready is only polled low: waiting out the full host delay would blow the run length,
        // and the bank takes writes in either phase
        acc(1'b0, 8'h00, 8'h00, {1'b0, `RDIB_REV_LOW, `RDIB_PART_ID});
        @(negedge ref_clk);
        check({7'h0, ready}, 8'h00);
        @(posedge ref_clk);
        acc(1'b1, 8'h00, 8'hff, 8'h00);
        acc(1'b0, 8'h00, 8'h00, {1'b0, `RDIB_REV_LOW, `RDIB_PART_ID});
        acc(1'b0, 8'h01, 8'h00, 8'h00);
        acc(1'b0, 8'hc6, 8'h00, `RDIB_REV_EXT_RESET);
        seed = lfsr(seed);
        acc(1'b1, 8'hc6, seed[7:0], 8'h00);
        acc(1'b0, 8'hc6, 8'h00, seed[7:0]);
        $display("identity test done");
        // every event bit once masked and once enabled
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            en = seed[7:0];
            en[i[2:0]] = i[3];
            ex = en & (8'h01 << i[2:0]);
            acc(1'b1, 8'h04, en & 8'h0f, 8'h00);
            acc(1'b1, 8'h05, en >> 4, 8'h00);
            acc(1'b0, 8'h04, 8'h00, en & 8'h0f);
            acc(1'b0, 8'h05, 8'h00, en >> 4);
            lev <= 8'h01 << i[2:0];
            repeat (4) @(posedge ref_clk);
            lev <= 8'h00;
            repeat (4) @(posedge ref_clk);
            irq_is(|ex);
            acc(1'b0, 8'h02, 8'h00, ex & 8'h0f);
            acc(1'b0, 8'h03, 8'h00, ex >> 4);
            acc(1'b1, 8'h02, 8'hff, 8'h00);
            irq_is(|(ex >> 4));
            acc(1'b1, 8'h03, 8'hff, 8'h00);
            irq_is(1'b0);
            $display("event %0d test done", i);
        end
        // a held event re-sets its flag in the very cycle that clears it
        acc(1'b1, 8'h04, 8'h01, 8'h00);
        lev <= 8'h01;
        repeat (6) @(posedge ref_clk);
        acc(1'b1, 8'h02, 8'hff, 8'h00);
        acc(1'b0, 8'h02, 8'h00, 8'h01);
        irq_is(1'b1);
        $display("set over clear test done");
        // mid-run reset drops flags, enables and revision back to their reset values
        rst <= 1'b1;
        lev <= 8'h00;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check({7'h0, ready}, 8'h00);
        irq_is(1'b0);
        acc(1'b0, 8'h02, 8'h00, 8'h00);
        acc(1'b0, 8'h04, 8'h00, 8'h00);
        acc(1'b0, 8'hc6, 8'h00, `RDIB_REV_EXT_RESET);
        acc(1'b0, 8'h00, 8'h00, {1'b0, `RDIB_REV_LOW, `RDIB_PART_ID});
        $display("reset test done");
        test_done();
    end
endmodule
